//--- hdl/ccp_pkg.sv
package ccp_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] ADDR_DATA_LO = 4'h0;
    localparam logic [3:0] ADDR_DATA_HI = 4'h1;
    localparam logic [3:0] ADDR_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_CONFIG = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h5;
    localparam logic [3:0] ADDR_PERIOD = 4'h6;
    localparam logic [3:0] ADDR_TCON = 4'h7;
    localparam logic [3:0] ADDR_TCOUNT = 4'h8;

    // Control register field positions
    localparam int CON_EN_BIT = 7;
    localparam int CON_OUT_BIT = 5;
    localparam int CON_FMT_BIT = 4;
    // Config register field positions
    localparam int CFG_TRIG_BIT = 0;
    localparam int CFG_EXTCLK_BIT = 1;
    localparam int CFG_DIR_BIT = 2;
    // Status and timer control field positions
    localparam int STS_UNIT_BIT = 0;
    localparam int STS_TIMER_BIT = 1;
    localparam int TCON_ON_BIT = 2;

    // Mode encodings
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOG_CLR = 4'h1;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_ANY = 4'h3;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4 = 4'h6;
    localparam logic [3:0] MODE_CAP_16 = 4'h7;
    localparam logic [3:0] MODE_SET = 4'h8;
    localparam logic [3:0] MODE_CLEAR = 4'h9;
    localparam logic [3:0] MODE_PULSE = 4'ha;
    localparam logic [3:0] MODE_PULSE_CLR = 4'hb;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;

    // Reset values and counts
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [3:0] PSC_LAST_4 = 4'h3;
    localparam logic [3:0] PSC_LAST_16 = 4'hf;
    localparam int SYS_PER_INSTR = 4;
    localparam logic [1:0] PULSE_LAST = 2'(SYS_PER_INSTR - 1);

    // Control register contents
    typedef struct packed {
        logic en;
        logic fmt;
        logic [3:0] mode;
    } ctrl_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

//--- hdl/capture_compare_pwm_unit.sv
`timescale 1ns/1ns
`default_nettype none
module capture_compare_pwm_unit (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire ccp_pkg::reg_req_t req_in,
    output logic [7:0] rd_data_out,
    // Odd timer resource and power state
    input wire logic [15:0] odd_timer_count_in,
    input wire logic sleep_in,
    output logic odd_timer_clear_out,
    // Pin and internal signals
    input wire logic unit_pin_in,
    output logic unit_pin_out,
    output logic unit_pin_oe_out,
    output logic unit_out_internal_out,
    output logic adc_trigger_out,
    output logic unit_irq_out
);
    import ccp_pkg::*;

    ctrl_t ctrl_q;
    logic [15:0] unit_data_reg_q;
    logic trig_sel_q, ext_clk_q, pin_direction_bit_q;
    logic unit_irq_flag_q, unit_irq_enable_q, pwm_timer_flag_q;
    logic [7:0] pwm_period_reg_q, pwm_timer_count_q;
    logic pwm_timer_on_q;
    logic [1:0] pwm_timer_prescale_q;
    logic [7:0] fine_q;
    logic [9:0] duty_buf_q;
    logic out_q;
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic [3:0] psc_q;
    logic match_q, clr_pend_q, start_q;
    logic [1:0] pulse_cnt_q;
    logic [7:0] fine_last;
    logic [1:0] fine_low;
    logic [9:0] duty_val, time_base;
    logic is_capture, is_compare, is_pwm, awake;
    logic rise, fall, cap_event, match, cmp_event, fine_wrap, period_hit;
    logic wr_ctrl, wr_status;

    // Mode decode and activity window
    assign is_capture = ctrl_q.en && ctrl_q.mode >= MODE_CAP_ANY && ctrl_q.mode <= MODE_CAP_16;
    assign is_pwm = ctrl_q.en && ctrl_q.mode[3:2] == MODE_PWM_TOP;
    assign is_compare = ctrl_q.en && !is_capture && !is_pwm && ctrl_q.mode != MODE_OFF;
    assign awake = !sleep_in || ext_clk_q;
    assign wr_ctrl = req_in.wr && req_in.addr == ADDR_CONTROL;
    assign wr_status = req_in.wr && req_in.addr == ADDR_STATUS;

    // Pin synchroniser
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= unit_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Capture event selection
    assign rise = pin_s2_q && !pin_s3_q;
    assign fall = !pin_s2_q && pin_s3_q;
    always_comb begin
        cap_event = 1'b0;
        if (is_capture && awake) begin
            case (ctrl_q.mode)
                MODE_CAP_ANY: cap_event = rise || fall;
                MODE_CAP_FALL: cap_event = fall;
                MODE_CAP_RISE: cap_event = rise;
                MODE_CAP_4: cap_event = rise && psc_q[1:0] == PSC_LAST_4[1:0];
                MODE_CAP_16: cap_event = rise && psc_q == PSC_LAST_16;
                default: cap_event = 1'b0;
            endcase
        end
    end

    // Capture prescaler; a ratio change alone leaves it running
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            psc_q <= 4'h0;
        end else if (!is_capture) begin
            psc_q <= 4'h0;
        end else if (rise && awake) begin
            psc_q <= (ctrl_q.mode == MODE_CAP_4 && psc_q[1:0] == PSC_LAST_4[1:0]) ?
                     4'h0 : psc_q + 4'h1;
        end
    end

    // Compare match, rising edge of equality
    assign match = is_compare && awake && odd_timer_count_in == unit_data_reg_q;
    assign cmp_event = match && !match_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    // Converter trigger now, timer clear one edge later if still matching
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            adc_trigger_out <= 1'b0;
            clr_pend_q <= 1'b0;
            odd_timer_clear_out <= 1'b0;
        end else begin
            adc_trigger_out <= cmp_event && trig_sel_q;
            clr_pend_q <= cmp_event &&
                          (ctrl_q.mode == MODE_TOG_CLR || ctrl_q.mode == MODE_PULSE_CLR);
            odd_timer_clear_out <= clr_pend_q && match;
        end
    end

    // PWM time base: fine counter supplies the two low bits
    always_comb begin
        case (pwm_timer_prescale_q)
            2'h0: begin
                fine_last = 8'h03;
                fine_low = fine_q[1:0];
            end
            2'h1: begin
                fine_last = 8'h0f;
                fine_low = fine_q[3:2];
            end
            2'h2: begin
                fine_last = 8'h3f;
                fine_low = fine_q[5:4];
            end
            default: begin
                fine_last = 8'hff;
                fine_low = fine_q[7:6];
            end
        endcase
    end
    assign time_base = {pwm_timer_count_q, fine_low};
    assign fine_wrap = pwm_timer_on_q && !sleep_in && fine_q == fine_last;
    assign period_hit = fine_wrap && pwm_timer_count_q == pwm_period_reg_q;
    assign duty_val = ctrl_q.fmt ? unit_data_reg_q[15:6] : unit_data_reg_q[9:0];

    // PWM timer, halted while off or asleep
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fine_q <= 8'h00;
            pwm_timer_count_q <= 8'h00;
        end else if (req_in.wr && req_in.addr == ADDR_TCOUNT) begin
            fine_q <= 8'h00;
            pwm_timer_count_q <= req_in.wdata;
        end else if (pwm_timer_on_q && !sleep_in) begin
            fine_q <= fine_wrap ? 8'h00 : fine_q + 8'h01;
            if (period_hit) begin
                pwm_timer_count_q <= 8'h00;
            end else if (fine_wrap) begin
                pwm_timer_count_q <= pwm_timer_count_q + 8'h01;
            end
        end
    end

    // Duty buffer reload at period end; latch set follows one cycle later
    // so that set and clear both lag the time base by the same cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            duty_buf_q <= 10'h000;
            start_q <= 1'b0;
        end else begin
            start_q <= period_hit && duty_val != 10'h000;
            if (period_hit) begin
                duty_buf_q <= duty_val;
            end
        end
    end

    // Output latch for compare and PWM
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_q <= 1'b0;
            pulse_cnt_q <= 2'h0;
        end else if (wr_ctrl && req_in.wdata == 8'h00) begin
            out_q <= 1'b0;
            pulse_cnt_q <= 2'h0;
        end else if (!ctrl_q.en) begin
            out_q <= 1'b0;
            pulse_cnt_q <= 2'h0;
        end else if (is_pwm) begin
            if (start_q) begin
                out_q <= 1'b1;
            end else if (time_base == duty_buf_q) begin
                out_q <= 1'b0;
            end
        end else if (pulse_cnt_q != 2'h0) begin
            pulse_cnt_q <= pulse_cnt_q - 2'h1;
            if (pulse_cnt_q == 2'h1) begin
                out_q <= 1'b0;
            end
        end else if (cmp_event) begin
            case (ctrl_q.mode)
                MODE_TOG_CLR, MODE_TOGGLE: out_q <= !out_q;
                MODE_SET: out_q <= 1'b1;
                MODE_CLEAR: out_q <= 1'b0;
                MODE_PULSE, MODE_PULSE_CLR: begin
                    out_q <= 1'b1;
                    pulse_cnt_q <= PULSE_LAST;
                end
                default: out_q <= out_q;
            endcase
        end
    end

    // Pin, internal copy and interrupt outputs
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_pin_out <= 1'b0;
            unit_pin_oe_out <= 1'b0;
            unit_out_internal_out <= 1'b0;
            unit_irq_out <= 1'b0;
        end else begin
            unit_pin_out <= out_q;
            unit_pin_oe_out <= !pin_direction_bit_q && (is_pwm || is_compare);
            unit_out_internal_out <= out_q;
            unit_irq_out <= unit_irq_flag_q && unit_irq_enable_q;
        end
    end

    // Control register; mode changes pass through unfiltered
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            ctrl_q.en <= req_in.wdata[CON_EN_BIT];
            ctrl_q.fmt <= req_in.wdata[CON_FMT_BIT];
            ctrl_q.mode <= req_in.wdata[3:0];
        end
    end

    // Data register: capture wins over a software write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_data_reg_q <= 16'h0000;
        end else if (cap_event) begin
            unit_data_reg_q <= odd_timer_count_in;
        end else if (req_in.wr && req_in.addr == ADDR_DATA_LO) begin
            unit_data_reg_q[7:0] <= req_in.wdata;
        end else if (req_in.wr && req_in.addr == ADDR_DATA_HI) begin
            unit_data_reg_q[15:8] <= req_in.wdata;
        end
    end

    // Flags: hardware set wins over a software write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_irq_flag_q <= 1'b0;
            pwm_timer_flag_q <= 1'b0;
        end else begin
            if (cap_event || cmp_event) begin
                unit_irq_flag_q <= 1'b1;
            end else if (wr_status) begin
                unit_irq_flag_q <= req_in.wdata[STS_UNIT_BIT];
            end
            if (period_hit) begin
                pwm_timer_flag_q <= 1'b1;
            end else if (wr_status) begin
                pwm_timer_flag_q <= req_in.wdata[STS_TIMER_BIT];
            end
        end
    end

    // Configuration and PWM timer registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_sel_q <= 1'b0;
            ext_clk_q <= 1'b0;
            pin_direction_bit_q <= 1'b1;
            unit_irq_enable_q <= 1'b0;
            pwm_period_reg_q <= PERIOD_RESET;
            pwm_timer_on_q <= 1'b0;
            pwm_timer_prescale_q <= 2'h0;
        end else if (req_in.wr) begin
            case (req_in.addr)
                ADDR_CONFIG: begin
                    trig_sel_q <= req_in.wdata[CFG_TRIG_BIT];
                    ext_clk_q <= req_in.wdata[CFG_EXTCLK_BIT];
                    pin_direction_bit_q <= req_in.wdata[CFG_DIR_BIT];
                end
                ADDR_IRQ_EN: unit_irq_enable_q <= req_in.wdata[0];
                ADDR_PERIOD: pwm_period_reg_q <= req_in.wdata;
                ADDR_TCON: begin
                    pwm_timer_on_q <= req_in.wdata[TCON_ON_BIT];
                    pwm_timer_prescale_q <= req_in.wdata[1:0];
                end
                default: pwm_timer_on_q <= pwm_timer_on_q;
            endcase
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (req_in.rd) begin
            case (req_in.addr)
                ADDR_DATA_LO: rd_data_out <= unit_data_reg_q[7:0];
                ADDR_DATA_HI: rd_data_out <= unit_data_reg_q[15:8];
                ADDR_CONTROL: rd_data_out <= {ctrl_q.en, 1'b0, out_q, ctrl_q.fmt, ctrl_q.mode};
                ADDR_CONFIG: rd_data_out <= {5'h00, pin_direction_bit_q, ext_clk_q, trig_sel_q};
                ADDR_STATUS: rd_data_out <= {6'h00, pwm_timer_flag_q, unit_irq_flag_q};
                ADDR_IRQ_EN: rd_data_out <= {7'h00, unit_irq_enable_q};
                ADDR_PERIOD: rd_data_out <= pwm_period_reg_q;
                ADDR_TCON: rd_data_out <= {5'h00, pwm_timer_on_q, pwm_timer_prescale_q};
                ADDR_TCOUNT: rd_data_out <= pwm_timer_count_q;
                default: rd_data_out <= 8'h00;
            endcase
        end else begin
            rd_data_out <= 8'h00;
        end
    end

    // Checks
    a_prescale_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        !is_capture |=> psc_q == 4'h0) else $error("prescaler not cleared");
    a_capture_copy: assert property (@(posedge clk_in) disable iff (rst_in)
        cap_event |=> unit_data_reg_q == $past(odd_timer_count_in) && unit_irq_flag_q)
        else $error("capture did not load count");
    a_match_flag: assert property (@(posedge clk_in) disable iff (rst_in)
        cmp_event |=> unit_irq_flag_q && adc_trigger_out == $past(trig_sel_q))
        else $error("match did not flag");
    a_clear_mode: assert property (@(posedge clk_in) disable iff (rst_in)
        odd_timer_clear_out |-> $past(clr_pend_q) && $past(match))
        else $error("timer clear without live match");
    a_clear_issue: assert property (@(posedge clk_in) disable iff (rst_in)
        cmp_event && ctrl_q.mode == MODE_TOG_CLR ##1 match |=> odd_timer_clear_out)
        else $error("timer clear missing");
    a_disabled_low: assert property (@(posedge clk_in) disable iff (rst_in)
        !ctrl_q.en |=> !out_q ##1 !unit_pin_out) else $error("latch high while off");
    a_zero_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ctrl && req_in.wdata == 8'h00 |=> !out_q) else $error("zero write kept latch");
    a_period_end: assert property (@(posedge clk_in) disable iff (rst_in)
        period_hit |=> pwm_timer_count_q == 8'h00 && duty_buf_q == $past(duty_val))
        else $error("period end mishandled");
    a_duty_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        is_pwm && !start_q && time_base == duty_buf_q && !wr_ctrl |=> !out_q)
        else $error("duty match kept pin high");
    a_internal_copy: assert property (@(posedge clk_in) disable iff (rst_in)
        ctrl_q.en |=> unit_out_internal_out == $past(out_q) && unit_pin_out == $past(out_q))
        else $error("internal copy differs");
endmodule
`default_nettype wire

//--- bench/odd_timer_model.sv
`timescale 1ns/1ns
`default_nettype none
module odd_timer_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Bench control
    input wire logic run_in,
    input wire logic sleep_in,
    input wire logic load_in,
    input wire logic [15:0] load_value_in,
    input wire logic pin_drive_in,
    // Unit side
    input wire logic clear_in,
    input wire logic pin_out_in,
    input wire logic pin_oe_in,
    output logic [15:0] count_out,
    output logic pin_level_out
);
    logic [1:0] phase_q;
    // Timer steps once per instruction clock, four system clocks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= 2'h0;
            count_out <= 16'h0000;
        end else begin
            phase_q <= phase_q + 2'h1;
            if (clear_in) begin
                count_out <= 16'h0000;
            end else if (load_in) begin
                count_out <= load_value_in;
            end else if (run_in && !sleep_in && phase_q == 2'h3) begin
                count_out <= count_out + 16'h0001;
            end
        end
    end
    // Wire level from both drivers
    assign pin_level_out = pin_oe_in ? pin_out_in : pin_drive_in;
endmodule
`default_nettype wire

//--- bench/test_capture_compare_pwm_unit.sv
`timescale 1ns/1ns
`default_nettype none
module test_capture_compare_pwm_unit;
    import ccp_pkg::*;
    logic clk_in, rst_in, sleep_in, run, load, pin_drive, pin_level;
    logic clr, pin_out, pin_oe, int_out, trig, irq;
    logic [15:0] load_val, tcount, v;
    logic [31:0] seed = 32'h2c89;
    logic [7:0] rd_data;
    logic [7:0] rq[$];
    logic rd_seen = 1'b0;
    reg_req_t req;
    int errors = 0;
    int num_checks = 0;
    int n, h, l, clrs;
    logic [3:0] m;
    logic p1, p2;
    logic [3:0] cap_m[5] = '{4'h4, 4'h5, 4'h3, 4'h6, 4'h7};
    int cap_n[5] = '{1, 1, 1, 4, 16};
    logic [3:0] cmp_m[6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb};

    capture_compare_pwm_unit i_capture_compare_pwm_unit (
        .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .rd_data_out(rd_data),
        .odd_timer_count_in(tcount), .sleep_in(sleep_in), .odd_timer_clear_out(clr),
        .unit_pin_in(pin_level), .unit_pin_out(pin_out), .unit_pin_oe_out(pin_oe),
        .unit_out_internal_out(int_out), .adc_trigger_out(trig), .unit_irq_out(irq));
    odd_timer_model i_odd_timer_model (
        .clk_in(clk_in), .rst_in(rst_in), .run_in(run), .sleep_in(sleep_in),
        .load_in(load), .load_value_in(load_val), .pin_drive_in(pin_drive),
        .clear_in(clr), .pin_out_in(pin_out), .pin_oe_in(pin_oe),
        .count_out(tcount), .pin_level_out(pin_level));

    // System clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req <= '0;
    endtask

    // Read request; expected value waits in the queue
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        rq.push_back(exp);
        @(posedge clk_in);
        req <= '0;
    endtask

    task automatic load_timer(input logic [15:0] val);
        @(posedge clk_in);
        load <= 1'b1;
        load_val <= val;
        @(posedge clk_in);
        load <= 1'b0;
    endtask

    task automatic pulse();
        @(posedge clk_in);
        pin_drive <= 1'b1;
        cyc(4);
        pin_drive <= 1'b0;
        cyc(4);
    endtask

    // Count cycles while the pin holds a level
    task automatic span(input logic lvl, output int k);
        k = 0;
        while (pin_out === lvl && k < 2000) begin
            @(negedge clk_in);
            k++;
        end
        if (k >= 2000) begin
            errors++;
            summarize();
        end
    endtask

    task automatic wait_match();
        n = 0;
        while (trig !== 1'b1 && n < 8) begin
            @(negedge clk_in);
            n++;
        end
        check(n < 8, 1'b1);
        clrs = 0;
        @(negedge clk_in);
        clrs += clr;
        p1 = pin_out;
        repeat (3) begin
            @(negedge clk_in);
            clrs += clr;
        end
        p2 = pin_out;
    endtask

    // Read data monitor, one cycle after the strobe
    always @(posedge clk_in) rd_seen <= req.rd;
    always @(negedge clk_in) begin
        if (rd_seen) begin
            if (rq.size() == 0) check(16'h0001, 16'h0000);
            else check({8'h00, rd_data}, {8'h00, rq.pop_front()});
        end
    end

    initial begin
        rst_in = 1'b1;
        req = '0;
        sleep_in = 1'b0;
        run = 1'b0;
        load = 1'b0;
        load_val = 16'h0000;
        pin_drive = 1'b0;
        cyc(2);
        rst_in <= 1'b0;
        // Reset values and an unmapped read
        rd(ADDR_CONTROL, 8'h00);
        rd(ADDR_CONFIG, 8'h04);
        rd(ADDR_PERIOD, 8'hff);
        rd(ADDR_TCOUNT, 8'h00);
        rd(4'hf, 8'h00);
        check(pin_oe, 1'b0);
        // Capture in every event mode
        wr(ADDR_IRQ_EN, 8'h00);
        for (int i = 0; i < 5; i++) begin
            v = 16'(rnd());
            load_timer(v);
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_CONTROL, {4'h8, cap_m[i]});
            wr(ADDR_STATUS, 8'h00);
            if (cap_n[i] > 1) begin
                repeat (2) pulse();
                wr(ADDR_CONTROL, 8'h00);
                wr(ADDR_CONTROL, {4'h8, cap_m[i]});
            end
            repeat (cap_n[i] - 1) pulse();
            rd(ADDR_STATUS, 8'h00);
            pulse();
            rd(ADDR_STATUS, 8'h01);
            rd(ADDR_DATA_LO, v[7:0]);
            rd(ADDR_DATA_HI, v[15:8]);
        end
        wr(ADDR_CONTROL, 8'h05);
        wr(ADDR_STATUS, 8'h00);
        pulse();
        rd(ADDR_STATUS, 8'h00);
        wr(ADDR_CONTROL, 8'h85);
        wr(ADDR_STATUS, 8'h00);
        sleep_in <= 1'b1;
        pulse();
        rd(ADDR_STATUS, 8'h00);
        sleep_in <= 1'b0;
        // Compare actions in every mode
        wr(ADDR_CONFIG, 8'h01);
        wr(ADDR_IRQ_EN, 8'h01);
        for (int i = 0; i < 6; i++) begin
            m = cmp_m[i];
            v = 16'(rnd());
            load_timer(~v);
            wr(ADDR_CONTROL, 8'h00);
            repeat (2) @(negedge clk_in);
            check(pin_out, 1'b0);
            wr(ADDR_CONTROL, {4'h8, m});
            wr(ADDR_DATA_LO, v[7:0]);
            wr(ADDR_DATA_HI, v[15:8]);
            wr(ADDR_STATUS, 8'h00);
            load_timer(v);
            wait_match();
            check(p1, m != 4'h9);
            check(p2, m != 4'h9 && m != 4'ha && m != 4'hb);
            check(clrs, (m == 4'h1 || m == 4'hb) ? 16'h1 : 16'h0);
            check(tcount, (m == 4'h1 || m == 4'hb) ? 16'h0 : v);
            check(int_out, pin_out);
            check({pin_oe, irq}, 2'h3);
            rd(ADDR_STATUS, 8'h01);
        end
        // Match removed in the cycle after the trigger edge
        v = 16'(rnd());
        wr(ADDR_CONTROL, 8'h81);
        wr(ADDR_DATA_LO, v[7:0]);
        wr(ADDR_DATA_HI, v[15:8]);
        load_timer(v);
        req <= '{addr: ADDR_DATA_LO, wdata: v[7:0] + 8'h01, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req <= '0;
        wait_match();
        check(clrs, 16'h0);
        // PWM period and duty, with prescale and alignment
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_CONFIG, 8'h04);
            wr(ADDR_TCON, 8'h00);
            wr(ADDR_TCOUNT, 8'h00);
            wr(ADDR_PERIOD, 8'h03);
            wr(ADDR_CONTROL, (k == 2) ? 8'h9c : 8'h8c);
            wr(ADDR_DATA_LO, (k == 2) ? 8'h80 : 8'h06);
            wr(ADDR_DATA_HI, (k == 2) ? 8'h01 : 8'h00);
            wr(ADDR_STATUS, 8'h00);
            wr(ADDR_TCON, (k == 1) ? 8'h05 : 8'h04);
            cyc(70);
            wr(ADDR_CONFIG, 8'h00);
            span(1'b1, n);
            span(1'b0, n);
            span(1'b1, h);
            span(1'b0, l);
            check(h, (k == 1) ? 16'd24 : 16'd6);
            check(h + l, (k == 1) ? 16'd64 : 16'd16);
        end
        wr(ADDR_DATA_LO, 8'h00);
        wr(ADDR_DATA_HI, 8'h00);
        cyc(40);
        h = 0;
        repeat (48) begin
            @(negedge clk_in);
            h += pin_out;
        end
        check(h, 16'h0);
        summarize();
    end
endmodule
`default_nettype wire
